/* File: tb/tap_ctrl_model.sv */
/* Test controller model: drives test clock, mode select and serial in.
   Assumes the caller steps it one test clock period at a time. */
`timescale 1ns/10ps
`default_nettype none
module tap_ctrl_model
  import tap_scan_pkg::*;
(
  output tap_pins_t pins
);
  initial pins = '0;
  // ----
  // Clock steps
  // ----
  task automatic cyc(input logic m, input logic d);
    pins.tck = 1'b0;
    pins.tms = m;
    pins.tdi = d;
    #(TCK_PERIOD_NS / 2);
    pins.tck = 1'b1;
    #(TCK_PERIOD_NS / 2);
  endtask
  // Clock parks low between frames; serial in flips so no stale bit looks valid
  task automatic park();
    pins.tck = 1'b0;
    pins.tdi = ~pins.tdi;
    #(TCK_PERIOD_NS);
  endtask
endmodule
`default_nettype wire

/* File: tb/tap_scan_monitor.sv */
/* Checker for tap_scan_port, seeing only its ports.
   Assumes a test clock of at least eight system clocks per period. */
`timescale 1ns/10ps
`default_nettype none
module tap_scan_monitor
  import tap_scan_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire tap_pins_t pinsIn,
  input wire logic [DR_WIDTH-1:0] captureData,
  input wire tap_out_t tdoPin,
  input wire logic [IR_WIDTH-1:0] activeIr,
  input wire logic [DR_WIDTH-1:0] userData,
  input wire logic [3:0] tapState
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ----
  // Port rules
  // ----
  exit_hiz_a:
    assert property ($rose(tapState inside {ST_EXIT1_IR, ST_EXIT1_DR}) |-> ##[1:12]
      !tdoPin.doutEn) else $error("serial out still driven after exit");
  ir_upd_a:
    assert property ($changed(activeIr) |-> tapState inside {ST_UPD_IR, ST_RESET})
      else $error("instruction changed outside update");
  byp_zero_a:
    assert property ($rose(tdoPin.doutEn) && tapState == ST_SHIFT_DR
      && activeIr != IR_USERDATA |-> !tdoPin.dout) else $error("bypass first bit not zero");
  shift_en_a:
    assert property ($rose(tapState == ST_SHIFT_DR) |-> ##[1:12] tdoPin.doutEn)
      else $error("serial out not enabled in shift");
  dr_upd_a:
    assert property ($changed(userData) |-> tapState == ST_UPD_DR)
      else $error("user data changed outside update");
  ir_first_a:
    assert property ($rose(tdoPin.doutEn) && tapState == ST_SHIFT_IR |-> tdoPin.dout)
      else $error("instruction capture bit not one");
  state_rise_a:
    assert property ($changed(tapState) |-> $past(pinsIn.tck, 2))
      else $error("state moved away from a rising test clock");
  en_fall_a:
    assert property ($changed(tdoPin.doutEn) |-> !$past(pinsIn.tck, 2))
      else $error("enable moved away from a falling test clock");
  leave_reset_a:
    assert property ($changed(tapState) && $past(tapState) == ST_RESET |->
      tapState == ST_IDLE) else $error("reset state left to wrong state");
  user_cap_a:
    assert property ($rose(tdoPin.doutEn) && tapState == ST_SHIFT_DR
      && activeIr == IR_USERDATA |-> tdoPin.dout == captureData[0])
      else $error("user register first bit not the captured value");
  hold_off_a:
    assert property (!clkEn |=> $stable(tapState) && $stable(tdoPin) && $stable(activeIr)
      && $stable(userData)) else $error("state moved while clock enable low");
endmodule
bind tap_scan_port tap_scan_monitor i_mon (.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn),
  .pinsIn(pinsIn), .captureData(captureData), .tdoPin(tdoPin), .activeIr(activeIr),
  .userData(userData), .tapState(tapState));
`default_nettype wire

/* File: tb/tap_scan_sequence_bypass_bench.sv */
/* Bench for tap_scan_port: scans through the controller model, checks serial
   out bits, instruction and user data.  Assumes tap_ctrl_model and the checker. */
`timescale 1ns/10ps
`default_nettype none
module tap_scan_sequence_bypass_bench;
  import tap_scan_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic [DR_WIDTH-1:0] captureData = '0;
  tap_pins_t pinsIn;
  tap_out_t tdoPin;
  logic [IR_WIDTH-1:0] activeIr;
  logic [DR_WIDTH-1:0] userData;
  logic [3:0] tapState;
  logic [7:0] expQ[$];
  logic [7:0] dd;
  logic [7:0] ud;
  int errors = 0;
  int checked = 0;
  always #(CLK_PERIOD_NS / 2.0) clock = ~clock;
  tap_scan_port i_dut (.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn), .pinsIn(pinsIn),
    .captureData(captureData), .tdoPin(tdoPin), .activeIr(activeIr), .userData(userData),
    .tapState(tapState));
  tap_ctrl_model i_ctl (.pins(pinsIn));
  // ----
  // Checking
  // ----
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // A driven bit with nothing expected is reported against EE
  always @(negedge pinsIn.tck) begin
    if (tdoPin.doutEn === 1'b1) begin
      if (expQ.size() == 0) chk(8'hEE, {7'h00, tdoPin.dout});
      else chk(expQ.pop_front(), {7'h00, tdoPin.dout});
    end
  end
  // ----
  // Scans from and back to idle
  // ----
  task automatic scan(input logic ir, input int n, input logic [7:0] din,
    input logic [7:0] dout);
    for (int i = 0; i < n; i++) expQ.push_back({7'h00, dout[i]});
    i_ctl.cyc(1'b1, 1'($urandom));
    if (ir) i_ctl.cyc(1'b1, 1'($urandom));
    i_ctl.cyc(1'b0, 1'($urandom));
    i_ctl.cyc(1'b0, 1'($urandom));
    for (int i = 0; i < n; i++) i_ctl.cyc(i == n - 1, din[i]);
    i_ctl.cyc(1'b1, 1'($urandom));
    i_ctl.cyc(1'b0, 1'($urandom));
    i_ctl.park();
  endtask
  initial begin
    #(400 * TCK_PERIOD_NS);
    errors++;
    results();
  end
  initial begin
    void'($urandom(32'h7F3A));
    repeat (12) @(posedge clock);
    #2 sys_rst = 1'b0;
    i_ctl.cyc(1'b0, 1'b0);
    scan(1'b1, IR_WIDTH, IR_USERDATA, IR_CAPTURE);
    chk(IR_USERDATA, activeIr);
    @(posedge clock);
    #2 captureData = 8'($urandom);
    ud = 8'($urandom);
    scan(1'b0, DR_WIDTH, ud, captureData);
    chk(ud, userData);
    $display("user register test done");
    scan(1'b1, IR_WIDTH, IR_BYPASS, IR_CAPTURE);
    chk(IR_BYPASS, activeIr);
    scan(1'b0, 3, 8'h05, 8'h02);
    repeat (4) begin
      dd = 8'($urandom);
      scan(1'b0, DR_WIDTH, dd, {dd[6:0], BYPASS_CAPTURE});
    end
    chk(ud, userData);
    $display("bypass test done");
    // A whole test-clock cycle with the enable low must leave the state alone
    clkEn = 1'b0;
    i_ctl.cyc(1'b1, 1'($urandom));
    i_ctl.park();
    clkEn = 1'b1;
    chk({4'h0, ST_IDLE}, {4'h0, tapState});
    $display("clock enable test done");
    scan(1'b1, IR_WIDTH, IR_USERDATA, IR_CAPTURE);
    repeat (3) i_ctl.cyc(1'b1, 1'($urandom));
    i_ctl.park();
    chk({4'h0, ST_RESET}, {4'h0, tapState});
    chk(IR_BYPASS, activeIr);
    chk(8'h00, 8'(expQ.size()));
    $display("reset test done");
    results();
  end
endmodule
`default_nettype wire

/* File: verilog/tap_edge_sync.sv */
/*
  Two-stage synchroniser for the test controller pins and an edge finder
  for the test clock.  Assumes pins are asynchronous to clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tap_edge_sync
  import tap_scan_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire tap_pins_t pinsIn,
  output tap_pins_t pinsSync,
  output logic tckRise,
  output logic tckFall
);

  tap_pins_t meta_ff;
  tap_pins_t sync_ff;
  logic tckLast_ff;
  tap_pins_t nxt_meta;
  tap_pins_t nxt_sync;
  logic nxt_tckLast;

  always_comb begin
    nxt_meta = meta_ff;
    nxt_sync = sync_ff;
    nxt_tckLast = tckLast_ff;
    if (sys_rst) begin
      nxt_meta = '0;
      nxt_sync = '0;
      nxt_tckLast = 1'b0;
    end else if (clkEn) begin
      nxt_meta = pinsIn;
      nxt_sync = meta_ff;
      nxt_tckLast = sync_ff.tck;
    end
  end

  always_ff @(posedge clock) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
    tckLast_ff <= nxt_tckLast;
  end

  assign pinsSync = sync_ff;
  // Edges seen only on the second stage, never the first
  assign tckRise = clkEn & sync_ff.tck & ~tckLast_ff;
  assign tckFall = clkEn & ~sync_ff.tck & tckLast_ff;

endmodule
`default_nettype wire

/* File: verilog/tap_scan_pkg.sv */
/*
  Shared types and constants for the test access port block: TAP states,
  instruction codes, capture patterns and pin groupings.
  Assumes a single system clock that oversamples the test clock.
*/
`default_nettype none
package tap_scan_pkg;

  // ----------------------------------------------------------------
  // TAP controller states, 4-bit codes changing up to three bits per step
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET    = 4'hF,
    ST_IDLE     = 4'hC,
    ST_SEL_DR   = 4'h7,
    ST_CAP_DR   = 4'h6,
    ST_SHIFT_DR = 4'h2,
    ST_EXIT1_DR = 4'h1,
    ST_PAUSE_DR = 4'h3,
    ST_EXIT2_DR = 4'h0,
    ST_UPD_DR   = 4'h5,
    ST_SEL_IR   = 4'h4,
    ST_CAP_IR   = 4'hE,
    ST_SHIFT_IR = 4'hA,
    ST_EXIT1_IR = 4'h9,
    ST_PAUSE_IR = 4'hB,
    ST_EXIT2_IR = 4'h8,
    ST_UPD_IR   = 4'hD
  } tap_state_t;

  localparam int IR_WIDTH = 8;
  localparam int DR_WIDTH = 8;
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 8'h81;
  localparam logic [IR_WIDTH-1:0] IR_BYPASS = 8'hFF;
  localparam logic [IR_WIDTH-1:0] IR_USERDATA = 8'h02;
  localparam logic [IR_WIDTH-1:0] IR_RESET_VALUE = IR_BYPASS;
  localparam logic BYPASS_CAPTURE = 1'b0;
  localparam logic [DR_WIDTH-1:0] DR_RESET_VALUE = 8'h00;

  // Test clock period in the bench and system clock period
  localparam int TCK_PERIOD_NS = 200;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TCK_CYCLES = TCK_PERIOD_NS / CLK_PERIOD_NS;

  // Pins coming from the test controller
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_t;

  // Serial data out as a three-state pin: data and enable
  typedef struct packed {
    logic dout;
    logic doutEn;
  } tap_out_t;

endpackage
`default_nettype wire

/* File: verilog/tap_scan_port.sv */
/*
  Test access port with instruction register, bypass register and one
  user data register.  The test clock is oversampled by clock; it must run
  well below clock/4.  Rising edges sample, falling edges drive and update.
  With clkEn low a whole test-clock pulse is lost, but a level change still standing when clkEn returns is seen late, so the
  surrounding logic must keep it high for whole scans.
*/
// Notes on behaviour
// - Serial out goes high impedance on falling edge in either Exit1 state.
// - Update-IR falling edge loads shifted instruction into active instruction.
// - With bypass selected, bypass bit captures zero leaving Capture-DR.
// - Entering Shift-DR, serial out enabled on falling edge; input valid then.
// - Serial input sampled on rising edges starting when leaving first shift.
// - Bypass path delays serial data by exactly one shift cycle.
// - With user data selected, Update-DR falling edge moves shifted data to the parallel output stage.
// - Leaving Capture-IR the instruction shift register loads 10000001.
// - Inputs sampled on rising edges; outputs driven on falling edges.
`timescale 1ns/10ps
`default_nettype none
module tap_scan_port
  import tap_scan_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire tap_pins_t pinsIn,
  input wire logic [DR_WIDTH-1:0] captureData,
  output tap_out_t tdoPin,
  output logic [IR_WIDTH-1:0] activeIr,
  output logic [DR_WIDTH-1:0] userData,
  output logic [3:0] tapState
);

  // ----------------------------------------------------------------
  // Pin synchronising
  // ----------------------------------------------------------------
  tap_pins_t pins;
  logic tckRise;
  logic tckFall;

  tap_edge_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .pinsIn(pinsIn),
    .pinsSync(pins),
    .tckRise(tckRise),
    .tckFall(tckFall)
  );

  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------
  // State codes change up to three bits per step along the scan paths
  // (Idle to Select-DR), and the debug view shows the raw code on a logic analyser
  tap_state_t state_ff;
  tap_state_t nxt_state;

  function automatic tap_state_t next_tap(input tap_state_t s, input logic m);
    case (s)
      ST_RESET: next_tap = m ? ST_RESET : ST_IDLE;
      ST_IDLE: next_tap = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_tap = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_tap = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_tap = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_tap = m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: next_tap = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_tap = m ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: next_tap = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_tap = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: next_tap = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_tap = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_tap = m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: next_tap = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_tap = m ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: next_tap = m ? ST_SEL_DR : ST_IDLE;
      default: next_tap = ST_RESET;
    endcase
  endfunction

  always_comb begin
    nxt_state = state_ff;
    if (sys_rst) begin
      // Synchronous reset outranks a test-clock edge in the same cycle
      nxt_state = ST_RESET;
    end else if (tckRise) begin
      nxt_state = next_tap(state_ff, pins.tms);
    end
  end

  always_ff @(posedge clock) begin
    state_ff <= nxt_state;
  end

  // ----------------------------------------------------------------
  // Shift registers, sampled on rising test-clock edges
  // ----------------------------------------------------------------
  // Only rising edges touch these; the falling edge reads them half a
  // test clock later, so shifting and driving never race
  logic [IR_WIDTH-1:0] irShift_ff;
  logic [IR_WIDTH-1:0] nxt_irShift;
  logic [DR_WIDTH-1:0] drShift_ff;
  logic [DR_WIDTH-1:0] nxt_drShift;
  logic bypass_ff;
  logic nxt_bypass;
  logic isBypass;
  // Active instruction is declared here because the decode below reads it
  logic [IR_WIDTH-1:0] activeIr_ff;
  logic [IR_WIDTH-1:0] nxt_activeIr;

  // Only the user code selects the wide register; every other code,
  // undefined ones included, takes the one-bit path so a stray
  // instruction never lengthens the chain the controller expects
  function automatic logic selects_bypass(input logic [IR_WIDTH-1:0] code);
    selects_bypass = (code != IR_USERDATA);
  endfunction

  assign isBypass = selects_bypass(activeIr_ff);

  always_comb begin
    nxt_irShift = irShift_ff;
    nxt_drShift = drShift_ff;
    nxt_bypass = bypass_ff;
    if (sys_rst) begin
      nxt_irShift = IR_CAPTURE;
      nxt_drShift = DR_RESET_VALUE;
      nxt_bypass = BYPASS_CAPTURE;
    end else if (tckRise) begin
      case (state_ff)
        ST_CAP_IR: nxt_irShift = IR_CAPTURE;
        ST_SHIFT_IR: nxt_irShift = {pins.tdi, irShift_ff[IR_WIDTH-1:1]};
        ST_CAP_DR: begin
          if (isBypass) begin
            nxt_bypass = BYPASS_CAPTURE;
          end else begin
            nxt_drShift = captureData;
          end
        end
        ST_SHIFT_DR: begin
          if (isBypass) begin
            nxt_bypass = pins.tdi;
          end else begin
            nxt_drShift = {pins.tdi, drShift_ff[DR_WIDTH-1:1]};
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    irShift_ff <= nxt_irShift;
    drShift_ff <= nxt_drShift;
    bypass_ff <= nxt_bypass;
  end

  // ----------------------------------------------------------------
  // Falling-edge outputs: serial out, enable, update stages
  // ----------------------------------------------------------------
  // Updates land on the falling edge, one and a half test clocks after the last
  // shift, so the parallel stages never see a half-shifted value
  logic [DR_WIDTH-1:0] userData_ff;
  logic [DR_WIDTH-1:0] nxt_userData;
  logic tdo_ff;
  logic nxt_tdo;
  logic tdoEn_ff;
  logic nxt_tdoEn;

  always_comb begin
    nxt_activeIr = activeIr_ff;
    nxt_userData = userData_ff;
    nxt_tdo = tdo_ff;
    nxt_tdoEn = tdoEn_ff;
    if (sys_rst) begin
      nxt_activeIr = IR_RESET_VALUE;
      nxt_userData = DR_RESET_VALUE;
      nxt_tdo = 1'b0;
      nxt_tdoEn = 1'b0;
    end else if (tckFall) begin
      case (state_ff)
        ST_RESET: nxt_activeIr = IR_RESET_VALUE;
        ST_SHIFT_IR: begin
          nxt_tdoEn = 1'b1;
          nxt_tdo = irShift_ff[0];
        end
        ST_SHIFT_DR: begin
          nxt_tdoEn = 1'b1;
          // Bypass bit holds the previous input, giving one cycle of delay
          nxt_tdo = isBypass ? bypass_ff : drShift_ff[0];
        end
        ST_UPD_IR: nxt_activeIr = irShift_ff;
        ST_UPD_DR: begin
          if (!isBypass) begin
            nxt_userData = drShift_ff;
          end
        end
        default: nxt_tdoEn = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    activeIr_ff <= nxt_activeIr;
    userData_ff <= nxt_userData;
    tdo_ff <= nxt_tdo;
    tdoEn_ff <= nxt_tdoEn;
  end

  // ----------------------------------------------------------------
  // Output ports
  // ----------------------------------------------------------------
  // Every port is a plain copy of a register, so nothing combinational
  // reaches the pins and the far side never sees a glitch
  assign tdoPin = '{dout: tdo_ff, doutEn: tdoEn_ff};
  assign activeIr = activeIr_ff;
  assign userData = userData_ff;
  // The state register itself is the debug view; a second copy would only
  // cost flops and could drift from it
  assign tapState = state_ff;

endmodule
`default_nettype wire
